// >>> rtl/srm_ctl.sv
// sdram refresh, idle level, manual access and queue service summary control block
`timescale 1ns/10ps
// Operation
// R1: refresh issued every programmed count of clocks, 16-bit register resetting to 0400h
// R2: software keeps refresh interval below half the worst refresh period
// R3: 16-bit writable lateness limit in refresh cycles
// R4: lateness reaching the limit sets the sticky refresh-late flag
// R5: disabled controller drives column, row, write strobes from idle bits 0..2
// R6: disabled controller drives bank select from idle bits 4:3, reset 3h
// R7: disabled controller drives address pins from 12-bit idle field, reset zero
// R8: manual trigger drives strobes for one clock from manual bits 0..2
// R9: manual access drives bank select from manual bits 4:3
// R10: manual access drives address pins from 12-bit manual field
// R11: 64 read-only queue service bits, reset zero
// R12: highest summary word holds queues 48 to 63, lsb first
// R13: next summary word holds queues 32 to 47, lsb first
// R14: interrupt held while latched flag and its enable are both set
// R15: remaining words hold queues 16 to 31 and 0 to 15
// R16: each summary bit is the or of enabled latched queue flags
module srm_ctl #(
    parameter int NQ = 64,
    parameter int NF = 4
) (
    // clock, reset, enable
    input  wire logic              sys_clk_in,
    input  wire logic              rst_in,
    input  wire logic              clk_en_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [13:0]       paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // queue flags from the per-queue registers, same clock
    input  wire logic [NQ*NF-1:0]  queue_flags_in,
    input  wire logic [NQ*NF-1:0]  queue_flag_en_in,
    // refresh engine handshake, same clock
    input  wire logic              refresh_done_in,
    input  wire logic [2:0]        ctl_strobes_in,
    input  wire logic [1:0]        ctl_bank_in,
    input  wire logic [11:0]       ctl_address_in,
    output logic                   refresh_req_out,
    // sdram pins
    output logic                   mem_column_strobe_n_out,
    output logic                   mem_row_strobe_n_out,
    output logic                   mem_write_strobe_n_out,
    output logic      [1:0]        mem_bank_select_out,
    output logic      [11:0]       mem_address_bus_out,
    // interrupt
    output logic                   irq_out
);

    // software registers
    logic [15:0] refresh_interval;
    logic [15:0] refresh_lateness_limit;
    logic [4:0]  idle_strobe_levels;
    logic [11:0] idle_address_level;
    logic [4:0]  manual_strobe_values;
    logic [11:0] manual_address_value;
    logic        sdram_enable;
    logic        refresh_late_flag;
    logic        refresh_overdue_irq_enable;
    logic        manual_pulse;
    // refresh state
    logic [15:0] interval_count;
    logic [15:0] late_count;
    logic [NQ-1:0] queue_serv;
    wire  [NQ-1:0] next_queue_serv;

    // bus decode
    wire [11:0] reg_index = paddr_in[13:2];
    wire        access    = psel_in & penable_in & clk_en_in;
    wire        wr        = access & pwrite_in;
    wire        rd        = access & ~pwrite_in;
    wire        hit_ri    = reg_index == srm_pkg::IDX_REFRESH_INTERVAL;
    wire        hit_ll    = reg_index == srm_pkg::IDX_REFRESH_LATE_LIMIT;
    wire        hit_is    = reg_index == srm_pkg::IDX_IDLE_STROBE;
    wire        hit_ia    = reg_index == srm_pkg::IDX_IDLE_ADDRESS;
    wire        hit_ms    = reg_index == srm_pkg::IDX_MANUAL_STROBE;
    wire        hit_ma    = reg_index == srm_pkg::IDX_MANUAL_ADDRESS;
    wire        hit_s4    = reg_index == srm_pkg::IDX_SUMMARY_HIGH;
    wire        hit_s3    = reg_index == srm_pkg::IDX_SUMMARY_UPPER_MID;
    wire        hit_s2    = reg_index == srm_pkg::IDX_SUMMARY_LOWER_MID;
    wire        hit_s1    = reg_index == srm_pkg::IDX_SUMMARY_LOW;
    wire        hit_st    = reg_index == srm_pkg::IDX_IRQ_STATUS;
    wire        hit_mk    = reg_index == srm_pkg::IDX_IRQ_MASK;
    wire        hit_ct    = reg_index == srm_pkg::IDX_CONTROL;
    wire        hit_any   = hit_ri | hit_ll | hit_is | hit_ia | hit_ms | hit_ma | hit_s4 | hit_s3
                          | hit_s2 | hit_s1 | hit_st | hit_mk | hit_ct;
    wire        man_trig  = wr & hit_ct & pwdata_in[srm_pkg::POS_CTL_MAN];

    // write strobes, taken at the access edge while pready stands
    wire        wr_take   = wr & pready_out;
    wire        wr_ri     = wr_take & hit_ri;
    wire        wr_ll     = wr_take & hit_ll;
    wire        wr_is     = wr_take & hit_is;
    wire        wr_ia     = wr_take & hit_ia;
    wire        wr_ms     = wr_take & hit_ms;
    wire        wr_ma     = wr_take & hit_ma;
    wire        wr_mk     = wr_take & hit_mk;
    wire        wr_ct     = wr_take & hit_ct;

    // per-queue service bit: or of enabled flags
    genvar q;
    generate
        for (q = 0; q < NQ; q++)
        begin : g_queue
            assign next_queue_serv[q] = |(queue_flags_in[q*NF +: NF] & queue_flag_en_in[q*NF +: NF]); // R16
        end
    endgenerate

    // summary bits registered, one clock behind the flags
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            queue_serv <= {NQ{1'b0}};
        else if (clk_en_in)
            queue_serv <= next_queue_serv; // R11
    end

    // read data select
    wire [15:0] next_rd16 =
        hit_ri ? refresh_interval :
        hit_ll ? refresh_lateness_limit :
        hit_is ? {11'h000, idle_strobe_levels} :
        hit_ia ? {4'h0, idle_address_level} :
        hit_ms ? {11'h000, manual_strobe_values} :
        hit_ma ? {4'h0, manual_address_value} :
        hit_s4 ? queue_serv[63:48] : // R12
        hit_s3 ? queue_serv[47:32] : // R13
        hit_s2 ? queue_serv[31:16] : // R15
        hit_s1 ? queue_serv[15:0] :  // R15
        hit_st ? {15'h0000, refresh_late_flag} :
        hit_mk ? {15'h0000, refresh_overdue_irq_enable} :
        hit_ct ? {15'h0000, sdram_enable} : 16'h0000;

    // refresh timing
    // an interval of 0 behaves like 1: the counter wraps every clock
    wire interval_hit = (refresh_interval <= 16'h0001) | (interval_count >= refresh_interval - 16'h0001); // R1
    wire late_reached = refresh_req_out & interval_hit & (late_count + 16'h0001 >= refresh_lateness_limit);
    wire late_clear   = wr & hit_st & pwdata_in[srm_pkg::POS_IRQ_LATE];

    // apb answer: zero wait, error on unmapped index
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~hit_any;
            prdata_out  <= {16'h0000, next_rd16};
        end
    end

    // refresh configuration registers
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            refresh_interval       <= srm_pkg::RST_REFRESH_INTERVAL;
            refresh_lateness_limit <= srm_pkg::RST_LATE_LIMIT;
        end
        else
        begin
            if (wr_ri)
                refresh_interval <= pwdata_in[15:0]; // R1
            if (wr_ll)
                refresh_lateness_limit <= pwdata_in[15:0]; // R3
        end
    end

    // idle pin levels, shown while the controller is disabled
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            idle_strobe_levels <= srm_pkg::RST_STROBE_LEVELS;
            idle_address_level <= srm_pkg::RST_ADDRESS;
        end
        else
        begin
            if (wr_is)
                idle_strobe_levels <= pwdata_in[4:0]; // R5 R6
            if (wr_ia)
                idle_address_level <= pwdata_in[11:0]; // R7
        end
    end

    // manual access pin values
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            manual_strobe_values <= srm_pkg::RST_STROBE_LEVELS;
            manual_address_value <= srm_pkg::RST_ADDRESS;
        end
        else
        begin
            if (wr_ms)
                manual_strobe_values <= pwdata_in[4:0]; // R8 R9
            if (wr_ma)
                manual_address_value <= pwdata_in[11:0]; // R10
        end
    end

    // controller enable and interrupt mask
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sdram_enable               <= 1'b0;
            refresh_overdue_irq_enable <= 1'b0;
        end
        else
        begin
            if (wr_ct)
                sdram_enable <= pwdata_in[srm_pkg::POS_CTL_EN];
            if (wr_mk)
                refresh_overdue_irq_enable <= pwdata_in[srm_pkg::POS_IRQ_LATE]; // R14
        end
    end

    // refresh interval counter and lateness tracking
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            interval_count  <= 16'h0000;
            late_count      <= 16'h0000;
            refresh_req_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            interval_count <= interval_hit ? 16'h0000 : interval_count + 16'h0001; // R1
            if (!sdram_enable | refresh_done_in)
            begin
                refresh_req_out <= 1'b0;
                late_count      <= 16'h0000;
            end
            else if (interval_hit)
            begin
                if (refresh_req_out)
                    late_count <= late_count + 16'h0001; // R3
                refresh_req_out <= 1'b1; // R1
            end
        end
    end

    // sticky late flag, set wins over clear
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            refresh_late_flag <= 1'b0;
        else if (clk_en_in)
        begin
            if (late_reached & sdram_enable)
                refresh_late_flag <= 1'b1; // R4
            else if (late_clear & pready_out)
                refresh_late_flag <= 1'b0;
        end
    end

    // manual access pulse lasts one clock
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            manual_pulse <= 1'b0;
        else if (clk_en_in)
            manual_pulse <= man_trig & pready_out; // R8
    end

    // pin source selection
    wire [4:0]  next_strobe = manual_pulse   ? manual_strobe_values :            // R8 R9
                              !sdram_enable ? idle_strobe_levels :              // R5 R6
                              {ctl_bank_in, ctl_strobes_in};
    wire [11:0] next_addr   = manual_pulse   ? manual_address_value :            // R10
                              !sdram_enable ? idle_address_level :              // R7
                              ctl_address_in;

    // registered pins and interrupt
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mem_column_strobe_n_out <= 1'b1;
            mem_row_strobe_n_out    <= 1'b1;
            mem_write_strobe_n_out  <= 1'b1;
            mem_bank_select_out     <= 2'h3;
            mem_address_bus_out     <= srm_pkg::RST_ADDRESS;
            irq_out                 <= 1'b0;
        end
        else if (clk_en_in)
        begin
            mem_column_strobe_n_out <= next_strobe[srm_pkg::POS_COL];
            mem_row_strobe_n_out    <= next_strobe[srm_pkg::POS_ROW];
            mem_write_strobe_n_out  <= next_strobe[srm_pkg::POS_WE];
            mem_bank_select_out     <= next_strobe[srm_pkg::POS_BANK_HI:srm_pkg::POS_BANK_LO];
            mem_address_bus_out     <= next_addr;
            irq_out                 <= refresh_late_flag & refresh_overdue_irq_enable; // R14
        end
    end

    // checks
    a_idle_pins: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R5
        clk_en_in & !sdram_enable & !manual_pulse |=> mem_column_strobe_n_out == $past(idle_strobe_levels[0]))
        else $error("idle strobe level not driven");
    a_idle_bank: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R6
        clk_en_in & !sdram_enable & !manual_pulse |=> mem_bank_select_out == $past(idle_strobe_levels[4:3]))
        else $error("idle bank level not driven");
    a_idle_addr: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R7
        clk_en_in & !sdram_enable & !manual_pulse |=> mem_address_bus_out == $past(idle_address_level))
        else $error("idle address not driven");
    a_manual_one: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R8
        clk_en_in & man_trig & pready_out |=> manual_pulse ##1 (!manual_pulse || !$past(clk_en_in)))
        else $error("manual pulse not one clock");
    a_manual_pins: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R9
        clk_en_in & manual_pulse |=> mem_bank_select_out == $past(manual_strobe_values[4:3]))
        else $error("manual bank not driven");
    a_manual_addr: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R10
        clk_en_in & manual_pulse |=> mem_address_bus_out == $past(manual_address_value))
        else $error("manual address not driven");
    a_late_sets: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R4
        clk_en_in & late_reached & sdram_enable |=> refresh_late_flag)
        else $error("late flag not set");
    a_irq_level: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R14
        clk_en_in |=> irq_out == $past(refresh_late_flag & refresh_overdue_irq_enable))
        else $error("interrupt level wrong");
    a_serv_map: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R16
        clk_en_in |=> queue_serv[48] == $past(|(queue_flags_in[192 +: 4] & queue_flag_en_in[192 +: 4])))
        else $error("queue 48 summary wrong");
    c_manual: cover property (@(posedge sys_clk_in) disable iff (rst_in) manual_pulse);
    c_late: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(refresh_late_flag));
    c_irq: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(irq_out));
    c_refresh: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(refresh_req_out));
    c_summary_read: cover property (@(posedge sys_clk_in) disable iff (rst_in) rd & hit_s4 & (next_rd16 != 16'h0000));

    // idle levels of the other two strobes
    a_idle_row: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R5
        clk_en_in & !sdram_enable & !manual_pulse |=> mem_row_strobe_n_out == $past(idle_strobe_levels[1]))
        else $error("idle row strobe not driven");
    a_idle_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R5
        clk_en_in & !sdram_enable & !manual_pulse |=> mem_write_strobe_n_out == $past(idle_strobe_levels[2]))
        else $error("idle write strobe not driven");
    // manual strobes
    a_manual_strobes: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R8
        clk_en_in & manual_pulse |=> {mem_write_strobe_n_out, mem_row_strobe_n_out, mem_column_strobe_n_out}
            == $past(manual_strobe_values[2:0]))
        else $error("manual strobes not driven");
    // refresh request, lateness count and flag clear
    a_refresh_req: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R1
        clk_en_in & sdram_enable & interval_hit & !refresh_done_in |=> refresh_req_out)
        else $error("refresh request not raised");
    a_late_count: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R3
        clk_en_in & sdram_enable & !refresh_done_in & interval_hit & refresh_req_out
            |=> late_count == $past(late_count) + 16'h0001)
        else $error("lateness count not advanced");
    a_late_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R4
        clk_en_in & late_clear & pready_out & !(late_reached & sdram_enable) |=> !refresh_late_flag)
        else $error("late flag not cleared");
    // summary words on the read bus
    a_serv_high: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R12
        clk_en_in & psel_in & !penable_in & hit_s4 |=> prdata_out[15:0] == $past(queue_serv[63:48]))
        else $error("high summary word wrong");
    a_serv_upper: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R13
        clk_en_in & psel_in & !penable_in & hit_s3 |=> prdata_out[15:0] == $past(queue_serv[47:32]))
        else $error("upper mid summary word wrong");

endmodule : srm_ctl

// >>> rtl/srm_pkg.sv
// package of register map, field layout and reset values for the sdram control block
package srm_pkg;
    // register offsets are not all multiples of four: these are indices, byte address is four times
    localparam logic [11:0] IDX_REFRESH_INTERVAL   = 12'h410;
    localparam logic [11:0] IDX_REFRESH_LATE_LIMIT = 12'h412;
    localparam logic [11:0] IDX_IDLE_STROBE        = 12'h420;
    localparam logic [11:0] IDX_IDLE_ADDRESS       = 12'h422;
    localparam logic [11:0] IDX_MANUAL_STROBE      = 12'h424;
    localparam logic [11:0] IDX_MANUAL_ADDRESS     = 12'h426;
    localparam logic [11:0] IDX_SUMMARY_HIGH       = 12'h438;
    localparam logic [11:0] IDX_SUMMARY_UPPER_MID  = 12'h43A;
    localparam logic [11:0] IDX_SUMMARY_LOWER_MID  = 12'h43C;
    localparam logic [11:0] IDX_SUMMARY_LOW        = 12'h43E;
    localparam logic [11:0] IDX_IRQ_STATUS         = 12'h402;
    localparam logic [11:0] IDX_IRQ_MASK           = 12'h404;
    localparam logic [11:0] IDX_CONTROL            = 12'h406;
    // field positions
    localparam int          POS_COL     = 0;
    localparam int          POS_ROW     = 1;
    localparam int          POS_WE      = 2;
    localparam int          POS_BANK_LO = 3;
    localparam int          POS_BANK_HI = 4;
    localparam int          POS_CTL_EN  = 0;
    localparam int          POS_CTL_MAN = 1;
    localparam int          POS_IRQ_LATE = 0;
    // reset values
    localparam logic [15:0] RST_REFRESH_INTERVAL = 16'h0400;
    localparam logic [15:0] RST_LATE_LIMIT       = 16'h0000;
    localparam logic [4:0]  RST_STROBE_LEVELS    = 5'h1F;
    localparam logic [11:0] RST_ADDRESS          = 12'h000;
    // refresh command levels (cas, ras, we low = auto refresh) and nop (all high)
    localparam logic [2:0]  CMD_REFRESH = 3'h0;
    localparam logic [2:0]  CMD_NOP     = 3'h7;
endpackage : srm_pkg

// >>> verification/srm_ctl_tb_top.sv
// self-checking testbench of the sdram control block
`timescale 1ns/10ps
module srm_ctl_tb_top;
    // apb, queue flags, refresh and pins
    logic         sys_clk;
    logic         rst     = 1'b1;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [13:0]  paddr   = 14'h0;
    logic [31:0]  pwdata  = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [255:0] qflags  = '0;
    logic [255:0] qen     = '0;
    logic [16:0]  ctl_pins = 17'h0;
    logic         stall   = 1'b0;
    logic         req;
    logic         done;
    logic         irq;
    wire  [16:0]  pins;
    int           errors  = 0;
    int           checks_done = 0;
    int           cyc     = 0;
    int           n;
    int           t0;
    int           t1;
    logic [31:0]  rd;
    logic [31:0]  d;
    logic         er;
    logic [31:0]  wv [6];
    // register indices with reset values, writable masks, summary words from queue 0 upward
    logic [11:0]  ridx [8] = '{12'h410, 12'h420, 12'h422, 12'h424, 12'h438, 12'h43A, 12'h43C, 12'h43E};
    logic [31:0]  rval [8] = '{32'h400, 32'h1F, 32'h0, 32'h1F, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [11:0]  widx [6] = '{12'h410, 12'h412, 12'h420, 12'h422, 12'h424, 12'h426};
    logic [31:0]  wmsk [6] = '{32'hFFFF, 32'hFFFF, 32'h1F, 32'hFFF, 32'h1F, 32'hFFF};
    logic [11:0]  sidx [4] = '{12'h43E, 12'h43C, 12'h43A, 12'h438};

    srm_ctl u_srm_ctl (.sys_clk_in(sys_clk), .rst_in(rst), .clk_en_in(1'b1), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .queue_flags_in(qflags),
        .queue_flag_en_in(qen), .refresh_done_in(done), .ctl_strobes_in(ctl_pins[2:0]),
        .ctl_bank_in(ctl_pins[4:3]), .ctl_address_in(ctl_pins[16:5]), .refresh_req_out(req),
        .mem_column_strobe_n_out(pins[0]), .mem_row_strobe_n_out(pins[1]), .mem_write_strobe_n_out(pins[2]),
        .mem_bank_select_out(pins[4:3]), .mem_address_bus_out(pins[16:5]), .irq_out(irq));
    srm_refresh_partner u_srm_refresh_partner (.sys_clk_in(sys_clk), .rst_in(rst),
        .refresh_req_in(req), .stall_in(stall), .refresh_done_out(done));

    // clock of 5 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            errors++;
            conclude();
        end
    end

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++k < 50);
        if (k >= 50)
            errors++;
        rdat    = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // cycle stamp of the next rising refresh request
    task automatic rise(output int t);
        int k;
        k = 0;
        do @(posedge sys_clk); while (req !== 1'b0 && ++k < 3000);
        do @(posedge sys_clk); while (req !== 1'b1 && ++k < 3000);
        if (k >= 3000)
            errors++;
        t = cyc;
    endtask : rise

    // expected summary word w, queues 16*w to 16*w+15 from lsb up
    function automatic logic [31:0] summary(input int w);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 16; i++)
            s[i] = |(qflags[(w*16+i)*4 +: 4] & qen[(w*16+i)*4 +: 4]);
        return s;
    endfunction : summary

    task automatic conclude();
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // main sequence
    initial
    begin
        void'($urandom(11924));
        ctl_pins = $urandom();
        repeat (12) @(posedge sys_clk);
        chk("idle pins at reset", {15'h0, 12'h000, 5'h1F}, {15'h0, pins});
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, ridx[i], 32'h0, rd, er);
            chk("reset value", rval[i], rd);
        end
        // writable registers, small refresh interval keeps the run short
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? $urandom_range(63, 8) : $urandom();
            wv[i] = d & wmsk[i];
            apb(1'b1, widx[i], d, rd, er);
            apb(1'b0, widx[i], 32'h0, rd, er);
            chk("readback", wv[i], rd);
        end
        chk("idle pins", {15'h0, wv[3][11:0], wv[2][4:0]}, {15'h0, pins});
        // manual access with values unlike the idle ones
        apb(1'b1, srm_pkg::IDX_MANUAL_STROBE, {27'h0, ~wv[2][4:0]}, rd, er);
        apb(1'b1, srm_pkg::IDX_MANUAL_ADDRESS, {20'h0, ~wv[3][11:0]}, rd, er);
        apb(1'b1, srm_pkg::IDX_CONTROL, 32'h2, rd, er);
        n = 0;
        repeat (8)
        begin
            @(posedge sys_clk);
            n += (pins === {~wv[3][11:0], ~wv[2][4:0]});
        end
        chk("manual cycles", 32'h1, n);
        chk("idle after manual", {15'h0, wv[3][11:0], wv[2][4:0]}, {15'h0, pins});
        apb(1'b0, 12'h7F0, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        // summaries: all set, all disabled, then random; writes to them are ignored
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                qflags[i*32 +: 32] <= (r == 0) ? 32'hFFFFFFFF : $urandom();
                qen[i*32 +: 32]    <= (r == 1) ? 32'h0 : (r == 0) ? 32'hFFFFFFFF : $urandom();
            end
            apb(1'b1, srm_pkg::IDX_SUMMARY_HIGH, 32'hFFFF, rd, er);
            for (int w = 0; w < 4; w++)
            begin
                apb(1'b0, sidx[w], 32'h0, rd, er);
                chk("summary", summary(w), rd);
            end
        end
        // refresh period with a prompt engine
        apb(1'b1, srm_pkg::IDX_CONTROL, 32'h1, rd, er);
        repeat (2) @(posedge sys_clk);
        chk("normal pins", {15'h0, ctl_pins}, {15'h0, pins});
        apb(1'b1, srm_pkg::IDX_REFRESH_INTERVAL, 32'd20, rd, er);
        rise(t0);
        rise(t0);
        rise(t1);
        chk("refresh period", 32'd20, t1 - t0);
        // lateness with a stalled engine, then interrupt masking and clearing
        apb(1'b1, srm_pkg::IDX_REFRESH_LATE_LIMIT, 32'h2, rd, er);
        apb(1'b1, srm_pkg::IDX_IRQ_STATUS, 32'h1, rd, er);
        stall <= 1'b1;
        rise(t0);
        apb(1'b0, srm_pkg::IDX_IRQ_STATUS, 32'h0, rd, er);
        chk("late too early", 32'h0, rd);
        repeat (70) @(posedge sys_clk);
        apb(1'b0, srm_pkg::IDX_IRQ_STATUS, 32'h0, rd, er);
        chk("late flag", 32'h1, rd);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, srm_pkg::IDX_IRQ_MASK, 32'h1, rd, er);
        repeat (2) @(posedge sys_clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        stall <= 1'b0;
        n = 0;
        do @(posedge sys_clk); while (req !== 1'b0 && ++n < 100);
        if (n >= 100)
            errors++;
        apb(1'b1, srm_pkg::IDX_IRQ_STATUS, 32'h1, rd, er);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b0, srm_pkg::IDX_IRQ_STATUS, 32'h0, rd, er);
        chk("late cleared", 32'h0, rd);
        conclude();
    end
endmodule : srm_ctl_tb_top

// >>> verification/srm_refresh_partner.sv
// refresh engine model that answers refresh requests promptly or stalls them
`timescale 1ns/10ps
module srm_refresh_partner (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    // request side
    input  wire logic refresh_req_in,
    input  wire logic stall_in,
    output logic      refresh_done_out
);
    logic [1:0] wait_cnt;

    // serve a request after three cycles with a one-cycle done pulse, hold off while stalled
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            refresh_done_out <= 1'b0;
            wait_cnt         <= 2'h0;
        end
        else if (refresh_done_out)
        begin
            refresh_done_out <= 1'b0;
            wait_cnt         <= 2'h0;
        end
        else if (refresh_req_in && !stall_in)
        begin
            refresh_done_out <= (wait_cnt == 2'h2);
            wait_cnt         <= wait_cnt + 2'h1;
        end
        else
            wait_cnt <= 2'h0;
    end
endmodule : srm_refresh_partner
